// ==== rtl/uhp_pkg.sv ====
// Shared constants and state types for the host-port serial controller
`default_nettype none
package uhp_pkg;
	// Register addresses on the two address pins
	localparam logic [1:0] ADDR_DATA = 2'h0;
	localparam logic [1:0] ADDR_LINE = 2'h1;
	localparam logic [1:0] ADDR_HS = 2'h2;
	localparam logic [1:0] ADDR_RATE = 2'h3;
	// handshake_control fields
	localparam int HC_DTR = 0;
	localparam int HC_RTS = 1;
	localparam int HC_GIE = 2;
	localparam int HC_MIE = 3;
	localparam int HC_MODE = 4;
	localparam int HC_RXEN = 6;
	localparam logic [7:0] HC_WMASK = 8'h7f;
	localparam logic [7:0] HC_RESET = 8'h00;
	localparam logic [1:0] MODE_BREAK = 2'h1;
	localparam logic [1:0] MODE_ECHO = 2'h2;
	localparam logic [1:0] MODE_LOOP = 2'h3;
	// line_control fields, length code in bits 1:0
	localparam int LC_PAR_EN = 2;
	localparam int LC_EVEN = 3;
	// line_status bit positions
	localparam int LS_PE = 0;
	localparam int LS_FE = 1;
	localparam int LS_OE = 2;
	localparam int LS_BRK = 3;
	localparam int LS_MCHG = 4;
	localparam int LS_TC = 5;
	localparam int LS_TX_HOLDING_EMPTY = 6;
	localparam int LS_DR = 7;
	// handshake_status bit positions and rate_select clock-out select
	localparam int HS_CTS = 0;
	localparam int HS_DSR = 1;
	localparam int RS_CO_SEL = 7;
	// Sixteenth-bit tick positions: mid start bit and end of a bit
	localparam logic [3:0] MID_TICK = 4'h7;
	localparam logic [3:0] LAST_TICK = 4'hf;
	// Synchroniser vector layout and idle levels
	localparam int SYNC_W = 17;
	localparam logic [16:0] SYNC_INIT = 17'h0fc00;
	localparam int SY_OSC = 16;
	localparam int SY_SIN = 15;
	localparam int SY_DSR = 14;
	localparam int SY_CTS = 13;
	localparam int SY_CS = 12;
	localparam int SY_WR = 11;
	localparam int SY_RD = 10;
	localparam int SY_ADDR = 8;
	// State machines
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
		TX_PAR = 3'b011, TX_STOP = 3'b100
	} uhp_tx_e;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
		RX_PAR = 3'b011, RX_STOP = 3'b100
	} uhp_rx_e;
endpackage : uhp_pkg
`default_nettype wire

// ==== rtl/uhp_sync.sv ====
// Two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module uhp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Pins in, synchronised copies out
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_sync;

	// First stage feeds only the second stage
	always_comb begin
		next_meta = async_i;
		next_sync = meta;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			meta <= INIT;
			sync_o <= INIT;
		end else begin
			meta <= next_meta;
			sync_o <= next_sync;
		end
	end
endmodule : uhp_sync
`default_nettype wire

// ==== rtl/uhp_uart.sv ====
// Byte-wide asynchronous serial controller: host port, handshake, tx and rx
`timescale 1ns/1ps
`default_nettype none
module uhp_uart (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Host bus
	input wire logic chip_select_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_n_o,
	// Serial line and handshake
	input wire logic serial_in_i,
	output logic serial_out_o,
	input wire logic clear_to_send_n_i,
	input wire logic data_set_ready_n_i,
	output logic term_ready_n_o,
	output logic req_to_send_n_o,
	// Oscillator, clock out and request pins
	input wire logic osc_in_i,
	output logic clock_out_o,
	output logic tx_holding_empty_o,
	output logic rx_data_ready_o,
	output logic irq_out_o
);
	import uhp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Synchronised pins
	logic [SYNC_W-1:0] sy;
	uhp_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
		.clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.async_i({osc_in_i, serial_in_i, data_set_ready_n_i, clear_to_send_n_i,
			chip_select_n_i, wr_n_i, rd_n_i, addr_i, data_i}),
		.sync_o(sy)
	);
	logic cts_t, dsr_t, wr_act, rd_act, wr_go, rd_go;
	logic [1:0] addr_s;
	logic [7:0] din_s;
	assign cts_t = ~sy[SY_CTS];
	assign dsr_t = ~sy[SY_DSR];
	assign addr_s = sy[SY_ADDR+:2];
	assign din_s = sy[7:0];
	assign wr_act = ~sy[SY_CS] & ~sy[SY_WR];
	assign rd_act = ~sy[SY_CS] & ~sy[SY_RD];

	// Register state
	logic [7:0] thr, receive_holding, lcr, hcr, rsel;
	logic tx_holding_empty, tc, dr, pe, fe, oe, brk, mchg, prog, cts_q, dsr_q, wr_q, rd_q;
	logic [7:0] next_thr, next_rbr, next_lcr, next_hcr, next_rsel, next_dout;
	logic next_tx_holding_empty, next_tc, next_dr, next_pe, next_fe, next_oe, next_brk;
	logic next_mchg, next_prog;
	logic [1:0] mode;
	logic loop, echo, brkm;
	assign wr_go = wr_act & ~wr_q;
	assign rd_go = rd_act & ~rd_q;
	assign mode = hcr[HC_MODE+:2];
	assign loop = mode == MODE_LOOP;
	assign echo = mode == MODE_ECHO;
	assign brkm = mode == MODE_BREAK;

	// Character format shared by both directions
	logic [2:0] last_bit;
	logic [7:0] len_mask;
	assign last_bit = 3'h4 + {1'b0, lcr[1:0]};
	assign len_mask = 8'hff >> (2'h3 - lcr[1:0]);

	////////////////////////////////////////////////////////////////////////////////
	// Rate divider: counts oscillator edges, toggles the 16x clock
	logic osc_q, bclk, next_bclk, next_clko, osc_rise, tick;
	logic [6:0] div, next_div;
	assign osc_rise = sy[SY_OSC] & ~osc_q;
	assign tick = prog & osc_rise & (div == rsel[6:0]) & ~bclk;

	// Held at zero until programmed so no tick is issued while idle
	always_comb begin
		next_div = div;
		next_bclk = bclk;
		next_clko = rsel[RS_CO_SEL] ? bclk : sy[SY_OSC];
		if (!prog) begin
			next_div = 7'h0;
			next_bclk = 1'b0;
		end else if (osc_rise) begin
			if (div == rsel[6:0]) begin
				next_div = 7'h0;
				next_bclk = ~bclk;
			end else begin
				next_div = div + 7'h1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		osc_q <= sy[SY_OSC];
		if (!rst_b_i) begin
			div <= 7'h0;
			bclk <= 1'b0;
			clock_out_o <= 1'b0;
		end else begin
			div <= next_div;
			bclk <= next_bclk;
			clock_out_o <= next_clko;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmitter
	uhp_tx_e txs, next_txs;
	logic [3:0] txcnt, next_txcnt;
	logic [2:0] txbit, next_txbit;
	logic [7:0] txsh, next_txsh;
	logic txpar, next_txpar, txline, next_txline, next_sout, tx_load;

	always_comb begin
		next_txs = txs;
		next_txcnt = txcnt;
		next_txbit = txbit;
		next_txsh = txsh;
		next_txpar = txpar;
		next_txline = txline;
		tx_load = 1'b0;
		unique case (txs)
			TX_IDLE: begin
				next_txline = 1'b1;
				// Echo disables the holding path; loop bypasses cts
				if (!tx_holding_empty && (cts_t || loop) && !echo) begin
					tx_load = 1'b1;
					next_txsh = brkm ? 8'h00 : thr;
					next_txpar = ~brkm & (^(thr & len_mask) ^ ~lcr[LC_EVEN]);
					next_txcnt = 4'h0;
					next_txs = TX_START;
					next_txline = 1'b0;
				end
			end
			// Once started, a character always runs to its stop bit
			TX_START, TX_DATA, TX_PAR, TX_STOP: if (tick) begin
				next_txcnt = txcnt + 4'h1;
				if (txcnt == LAST_TICK) begin
					unique case (txs)
						TX_START: begin
							next_txs = TX_DATA;
							next_txbit = 3'h0;
							next_txline = txsh[0];
						end
						TX_DATA: begin
							if (txbit == last_bit) begin
								next_txs = lcr[LC_PAR_EN] ? TX_PAR : TX_STOP;
								next_txline = lcr[LC_PAR_EN] ? txpar : ~brkm;
							end else begin
								next_txbit = txbit + 3'h1;
								next_txsh = {1'b0, txsh[7:1]};
								next_txline = txsh[1];
							end
						end
						TX_PAR: begin
							next_txs = TX_STOP;
							next_txline = ~brkm;
						end
						default: begin
							next_txs = TX_IDLE;
							next_txline = 1'b1;
						end
					endcase
				end
			end
			default: next_txs = TX_IDLE;
		endcase
		// Echo passes the line through raw, parity included
		if (echo) begin
			next_sout = sy[SY_SIN];
		end else begin
			next_sout = loop | txline;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			txs <= TX_IDLE;
			txcnt <= 4'h0;
			txbit <= 3'h0;
			txsh <= 8'h00;
			txpar <= 1'b0;
			txline <= 1'b1;
			serial_out_o <= 1'b1;
		end else begin
			txs <= next_txs;
			txcnt <= next_txcnt;
			txbit <= next_txbit;
			txsh <= next_txsh;
			txpar <= next_txpar;
			txline <= next_txline;
			serial_out_o <= next_sout;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receiver
	uhp_rx_e rxs, next_rxs;
	logic [3:0] rxcnt, next_rxcnt;
	logic [2:0] rxbit, next_rxbit;
	logic [7:0] rxsh, next_rxsh;
	logic rxpar, next_rxpar, rx_in, rx_done;

	// Loop feeds the receiver from the transmitter, never from the pin
	assign rx_in = ~hcr[HC_RXEN] | (loop ? txline : sy[SY_SIN]);

	always_comb begin
		next_rxs = rxs;
		next_rxcnt = rxcnt;
		next_rxbit = rxbit;
		next_rxsh = rxsh;
		next_rxpar = rxpar;
		rx_done = 1'b0;
		unique case (rxs)
			RX_IDLE: if (!rx_in && prog) begin
				next_rxs = RX_START;
				next_rxcnt = 4'h0;
			end
			// Start bit rechecked at mid bit to reject glitches
			RX_START: if (tick) begin
				next_rxcnt = rxcnt + 4'h1;
				if (rxcnt == MID_TICK) begin
					next_rxs = rx_in ? RX_IDLE : RX_DATA;
					next_rxcnt = 4'h0;
					next_rxbit = 3'h0;
					next_rxsh = 8'h00;
					next_rxpar = 1'b0;
				end
			end
			RX_DATA, RX_PAR, RX_STOP: if (tick) begin
				next_rxcnt = rxcnt + 4'h1;
				if (rxcnt == LAST_TICK) begin
					unique case (rxs)
						RX_DATA: begin
							next_rxsh[rxbit] = rx_in;
							next_rxbit = rxbit + 3'h1;
							if (rxbit == last_bit) begin
								next_rxs = lcr[LC_PAR_EN] ? RX_PAR : RX_STOP;
							end
						end
						RX_PAR: begin
							next_rxpar = rx_in;
							next_rxs = RX_STOP;
						end
						default: begin
							rx_done = 1'b1;
							next_rxs = RX_IDLE;
						end
					endcase
				end
			end
			default: next_rxs = RX_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			rxs <= RX_IDLE;
			rxcnt <= 4'h0;
			rxbit <= 3'h0;
			rxsh <= 8'h00;
			rxpar <= 1'b0;
		end else begin
			rxs <= next_rxs;
			rxcnt <= next_rxcnt;
			rxbit <= next_rxbit;
			rxsh <= next_rxsh;
			rxpar <= next_rxpar;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Host registers, status flags and request pins
	logic wr_data, rd_data, rd_hs, cts_chg, dsr_chg, next_irq;
	assign wr_data = wr_go & (addr_s == ADDR_DATA);
	assign rd_data = rd_go & (addr_s == ADDR_DATA);
	assign rd_hs = rd_go & (addr_s == ADDR_RATE);
	assign cts_chg = cts_t != cts_q;
	assign dsr_chg = dsr_t != dsr_q;

	always_comb begin
		next_thr = thr;
		next_rbr = receive_holding;
		next_lcr = lcr;
		next_hcr = hcr;
		next_rsel = rsel;
		next_prog = prog;
		next_pe = pe;
		next_fe = fe;
		next_oe = oe;
		next_brk = brk;
		next_dout = data_o;
		// Writes decoded by address
		if (wr_go) begin
			unique case (addr_s)
				ADDR_DATA: next_thr = din_s;
				ADDR_LINE: next_lcr = din_s;
				ADDR_HS: begin
					next_hcr = din_s & HC_WMASK;
					next_prog = 1'b1;
				end
				ADDR_RATE: next_rsel = din_s;
			endcase
		end
		// Reads latch at the strobe's leading edge
		if (rd_go) begin
			unique case (addr_s)
				ADDR_DATA: next_dout = receive_holding;
				ADDR_LINE: next_dout = {dr, tx_holding_empty, tc, mchg, brk, oe, fe, pe};
				ADDR_HS: next_dout = hcr;
				ADDR_RATE: next_dout = {6'h00, dsr_t, cts_t};
			endcase
		end
		// Holding handoff sets empty; a host write in the same cycle wins
		next_tx_holding_empty = (tx_holding_empty | tx_load) & ~wr_data;
		next_tc = next_tx_holding_empty & (txs == TX_IDLE) & ~tx_load;
		// Set wins over the read that clears
		next_mchg = cts_chg | dsr_chg | (mchg & ~rd_hs);
		next_dr = dr & ~rd_data;
		if (rx_done) begin
			next_oe = next_dr;
			next_fe = ~rx_in;
			next_pe = lcr[LC_PAR_EN] & (^rxsh ^ rxpar ^ ~lcr[LC_EVEN]);
			next_brk = ~rx_in & (rxsh == 8'h00) & ~rxpar;
			if (!next_dr) begin
				next_rbr = rxsh;
				next_dr = 1'b1;
			end
		end
		next_irq = hcr[HC_GIE] & (tc | (hcr[HC_MIE] & mchg));
	end

	always_ff @(posedge sys_clk_i) begin
		thr <= next_thr;
		receive_holding <= next_rbr;
		lcr <= next_lcr;
		rsel[6:0] <= next_rsel[6:0];
		cts_q <= cts_t;
		dsr_q <= dsr_t;
		data_o <= next_dout;
		if (!rst_b_i) begin
			hcr <= HC_RESET;
			rsel[RS_CO_SEL] <= 1'b0;
			prog <= 1'b0;
			tx_holding_empty <= 1'b1;
			tc <= 1'b1;
			dr <= 1'b0;
			pe <= 1'b0;
			fe <= 1'b0;
			oe <= 1'b0;
			brk <= 1'b0;
			mchg <= 1'b0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			data_oe_n_o <= 1'b1;
			term_ready_n_o <= 1'b1;
			req_to_send_n_o <= 1'b1;
			tx_holding_empty_o <= 1'b1;
			rx_data_ready_o <= 1'b0;
			irq_out_o <= 1'b0;
		end else begin
			hcr <= next_hcr;
			rsel[RS_CO_SEL] <= next_rsel[RS_CO_SEL];
			prog <= next_prog;
			tx_holding_empty <= next_tx_holding_empty;
			tc <= next_tc;
			dr <= next_dr;
			pe <= next_pe;
			fe <= next_fe;
			oe <= next_oe;
			brk <= next_brk;
			mchg <= next_mchg;
			wr_q <= wr_act;
			rd_q <= rd_act;
			data_oe_n_o <= ~rd_act;
			term_ready_n_o <= ~next_hcr[HC_DTR];
			req_to_send_n_o <= ~next_hcr[HC_RTS];
			tx_holding_empty_o <= next_tx_holding_empty;
			rx_data_ready_o <= next_dr;
			irq_out_o <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_cts_chg;
		cts_chg ##1 (hcr[HC_GIE] && hcr[HC_MIE]);
	endsequence
	sequence s_dsr_chg;
		dsr_chg ##1 (hcr[HC_GIE] && hcr[HC_MIE]);
	endsequence
	property p_cts_irq;
		s_cts_chg |=> irq_out_o;
	endproperty
	a_cts_irq: assert property (p_cts_irq) else $error("cts change gave no irq");
	property p_dsr_irq;
		s_dsr_chg |=> irq_out_o;
	endproperty
	a_dsr_irq: assert property (p_dsr_irq) else $error("dsr change gave no irq");
	property p_cts_block;
		txs == TX_IDLE && !cts_t && !loop |=> txs == TX_IDLE;
	endproperty
	a_cts_block: assert property (p_cts_block) else $error("tx started with cts false");
	// A dropped cts mid character must not force mark or abort the frame
	property p_finish;
		txs == TX_DATA && !cts_t && !loop && !echo |=> txs != TX_IDLE && serial_out_o == $past(txline);
	endproperty
	a_finish: assert property (p_finish) else $error("character cut short");
	property p_loop_start;
		loop && !tx_holding_empty && txs == TX_IDLE |=> txs == TX_START;
	endproperty
	a_loop_start: assert property (p_loop_start) else $error("loop start held by cts");
	property p_dtr;
		wr_go && addr_s == ADDR_HS |=> term_ready_n_o == !$past(din_s[HC_DTR]);
	endproperty
	a_dtr: assert property (p_dtr) else $error("terminal ready wrong");
	property p_rts;
		wr_go && addr_s == ADDR_HS |=> req_to_send_n_o == !$past(din_s[HC_RTS]);
	endproperty
	a_rts: assert property (p_rts) else $error("request to send wrong");
	property p_clk_out;
		rsel[RS_CO_SEL] |=> clock_out_o == $past(bclk);
	endproperty
	a_clk_out: assert property (p_clk_out) else $error("clock out source wrong");
	property p_tx_holding_empty_clr;
		wr_data |=> !tx_holding_empty_o ##1 !tc;
	endproperty
	a_tx_holding_empty_clr: assert property (p_tx_holding_empty_clr) else $error("holding write kept empty");
	property p_dr_clr;
		rd_data && !rx_done |=> !rx_data_ready_o;
	endproperty
	a_dr_clr: assert property (p_dr_clr) else $error("data ready not cleared");
	property p_irq_off;
		!hcr[HC_GIE] |=> !irq_out_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq with global enable off");
	property p_mark;
		txs == TX_IDLE && !echo |=> serial_out_o;
	endproperty
	a_mark: assert property (p_mark) else $error("serial out not mark");
endmodule : uhp_uart
`default_nettype wire

// ==== test/uhp_line_model.sv ====
// Behavioural serial line and modem handshake partner for the host-port controller
`timescale 1ns/1ps
`default_nettype none
module uhp_line_model #(
	parameter int BIT_NS = 3008
) (
	// Serial line and handshake pins
	input wire logic serial_out_i,
	output logic serial_in_o,
	output logic cts_n_o,
	output logic dsr_n_o
);
	// Idle line rests at mark, handshake lines start false
	initial begin
		serial_in_o = 1'b1;
		cts_n_o = 1'b1;
		dsr_n_o = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////
	// Level changes are issued on a clock edge by the caller
	task automatic set_lines(input logic cts_n, input logic dsr_n, input logic sin);
		cts_n_o <= cts_n;
		dsr_n_o <= dsr_n;
		serial_in_o <= sin;
	endtask : set_lines
	// Eight data bits, low bit first, one stop bit; timing is free-running
	task automatic send_byte(input logic [7:0] b);
		serial_in_o = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			serial_in_o = b[i];
			#(BIT_NS);
		end
		serial_in_o = 1'b1;
		#(BIT_NS);
	endtask : send_byte
	// Sample each bit at its middle, so small rate slips still land safely
	task automatic get_byte(output logic [7:0] b, output logic stop);
		@(negedge serial_out_i);
		#(BIT_NS / 2);
		for (int i = 0; i < 8; i++) begin
			#(BIT_NS);
			b[i] = serial_out_i;
		end
		#(BIT_NS);
		stop = serial_out_i;
	endtask : get_byte
endmodule : uhp_line_model
`default_nettype wire

// ==== test/test_uhp_uart.sv ====
// Self-checking bench for the host-port serial controller
`timescale 1ns/1ps
`default_nettype none
module test_uhp_uart;
	import uhp_pkg::*;
	// Oscillator period chosen off the system grid so the two never align
	localparam int OSC_NS = 94;
	localparam int BIT_CLKS = 2 * 16 * OSC_NS / 25 + 1;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [7:0] din = 8'h00;
	logic osc = 1'b0;
	logic [7:0] dout;
	logic doe_n, sin, sout, cts_n, dsr_n, dtr_n, rts_n, co, tx_holding_empty, dr, irq;
	int n_mismatch = 0;
	int n_checks = 0;
	// Clocks
	always #12.5 sys_clk = ~sys_clk;
	always #(OSC_NS / 2) osc = ~osc;
	////////////////////////////////////////////////////////////////////////////
	uhp_uart i_dut (
		.sys_clk_i(sys_clk), .rst_b_i(rst_b), .chip_select_n_i(cs_n),
		.rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr), .data_i(din), .data_o(dout),
		.data_oe_n_o(doe_n), .serial_in_i(sin), .serial_out_o(sout),
		.clear_to_send_n_i(cts_n), .data_set_ready_n_i(dsr_n), .term_ready_n_o(dtr_n),
		.req_to_send_n_o(rts_n), .osc_in_i(osc), .clock_out_o(co),
		.tx_holding_empty_o(tx_holding_empty), .rx_data_ready_o(dr), .irq_out_o(irq)
	);
	uhp_line_model #(.BIT_NS(2 * 16 * OSC_NS)) i_line (
		.serial_out_i(sout), .serial_in_o(sin), .cts_n_o(cts_n), .dsr_n_o(dsr_n)
	);
	////////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	// Address and data settle three clocks ahead, since they pass the same synchroniser
	task automatic bus(input logic cs, input logic wr, input logic [1:0] a,
			input logic [7:0] d, output logic [7:0] q);
		@(posedge sys_clk);
		cs_n <= !cs;
		addr <= a;
		din <= d;
		cyc(3);
		wr_n <= !wr;
		rd_n <= wr;
		cyc(5);
		q = dout;
		if (!wr) chk(doe_n, !cs, "data drive");
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		cyc(1);
		cs_n <= 1'b1;
		cyc(4);
	endtask : bus
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, 1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		logic [7:0] q;
		bus(1'b1, 1'b0, a, 8'h00, q);
		chk(q, exp, "register read");
	endtask : rd
	task automatic hold_mark(input int n);
		int lows = 0;
		repeat (n) begin
			@(posedge sys_clk);
			if (sout !== 1'b1) lows++;
		end
		chk(lows == 0, 1'b1, "line held at mark");
	endtask : hold_mark
	task automatic co_rate(input int exp);
		int n = 0;
		logic prev = co;
		repeat (1000) begin
			@(posedge sys_clk);
			if (co && !prev) n++;
			prev = co;
		end
		chk(n > exp - 5 && n < exp + 5, 1'b1, "clock out rate");
	endtask : co_rate
	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		@(posedge sys_clk);
		rst_b <= 1'b0;
		cyc(10);
		rst_b <= 1'b1;
		cyc(2);
		chk({doe_n, sout, dtr_n, rts_n, tx_holding_empty, dr, irq}, 8'h7c, "reset pins");
		rd(ADDR_LINE, 8'h60);
		rd(ADDR_HS, HC_RESET);
		$display("test reset done");
	endtask : t_reset
	task automatic t_select;
		logic [7:0] q;
		bus(1'b0, 1'b1, ADDR_HS, 8'h03, q);
		bus(1'b0, 1'b0, ADDR_HS, 8'h00, q);
		chk({dtr_n, rts_n}, 8'h03, "deselected write");
		$display("test select done");
	endtask : t_select
	task automatic t_hs;
		wr(ADDR_LINE, 8'h03);
		wr(ADDR_RATE, 8'h00);
		wr(ADDR_HS, 8'h03);
		chk({dtr_n, rts_n}, 8'h00, "both asserted");
		rd(ADDR_HS, 8'h03);
		wr(ADDR_HS, 8'h01);
		chk({dtr_n, rts_n}, 8'h01, "terminal ready only");
		wr(ADDR_HS, 8'h00);
		chk({dtr_n, rts_n}, 8'h03, "both released");
		$display("test handshake done");
	endtask : t_hs
	task automatic t_tx;
		logic [7:0] b;
		logic stop;
		wr(ADDR_HS, 8'h04);
		chk(irq, 1'b1, "idle done irq");
		wr(ADDR_DATA, 8'ha5);
		hold_mark(4 * BIT_CLKS);
		chk(tx_holding_empty, 1'b0, "byte still held");
		fork
			i_line.get_byte(b, stop);
			begin
				i_line.set_lines(1'b0, 1'b1, 1'b1);
				cyc(BIT_CLKS);
				wr(ADDR_DATA, 8'h3c);
				chk(tx_holding_empty, 1'b0, "second byte held");
				chk(irq, 1'b0, "busy no irq");
				i_line.set_lines(1'b0, 1'b0, 1'b1);
				cyc(8);
				chk(irq, 1'b0, "masked modem change");
				wr(ADDR_HS, 8'h0c);
				chk(irq, 1'b1, "modem change irq");
				rd(ADDR_RATE, 8'h03);
				chk(irq, 1'b0, "change cleared");
				i_line.set_lines(1'b1, 1'b0, 1'b1);
			end
		join
		chk(b, 8'ha5, "first byte");
		chk(stop, 1'b1, "first byte finished");
		hold_mark(2 * BIT_CLKS);
		i_line.set_lines(1'b0, 1'b0, 1'b1);
		i_line.get_byte(b, stop);
		chk(b, 8'h3c, "second byte");
		chk(tx_holding_empty, 1'b1, "holding handed over");
		cyc(BIT_CLKS);
		chk(irq, 1'b1, "done irq");
		wr(ADDR_HS, 8'h08);
		chk(irq, 1'b0, "global enable off");
		$display("test transmit done");
	endtask : t_tx
	task automatic t_loop;
		i_line.set_lines(1'b1, 1'b1, 1'b0);
		wr(ADDR_HS, 8'h70);
		wr(ADDR_DATA, 8'h5a);
		hold_mark(11 * BIT_CLKS);
		chk(dr, 1'b1, "looped byte ready");
		rd(ADDR_DATA, 8'h5a);
		chk(dr, 1'b0, "ready cleared by read");
		i_line.set_lines(1'b1, 1'b1, 1'b1);
		wr(ADDR_HS, 8'h00);
		$display("test loop done");
	endtask : t_loop
	// Echo repeats the line raw; the holding path stays idle
	task automatic t_echo;
		logic [7:0] b;
		logic stop;
		wr(ADDR_HS, 8'h20);
		fork
			i_line.get_byte(b, stop);
			i_line.send_byte(8'h96);
		join
		chk(b, 8'h96, "echoed byte");
		chk(stop, 1'b1, "echoed stop");
		wr(ADDR_HS, 8'h00);
		$display("test echo done");
	endtask : t_echo
	task automatic t_clk;
		wr(ADDR_RATE, 8'h80);
		co_rate(25000 / (2 * OSC_NS));
		t_reset();
		co_rate(25000 / OSC_NS);
		$display("test clock out done");
	endtask : t_clk
	// Format and rate were kept through the reset, so only the receiver is enabled
	task automatic t_rx;
		wr(ADDR_HS, 8'h40);
		i_line.send_byte(8'hc3);
		for (int i = 0; i < 2 * BIT_CLKS && dr !== 1'b1; i++) @(posedge sys_clk);
		chk(dr, 1'b1, "data ready");
		rd(ADDR_LINE, 8'he0);
		rd(ADDR_DATA, 8'hc3);
		chk(dr, 1'b0, "ready cleared");
		$display("test receive done");
	endtask : t_rx
	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict
	// Watchdog well beyond the roughly ten thousand cycles the tests need
	initial begin
		repeat (40000) @(posedge sys_clk);
		n_mismatch++;
		$display("ERROR %0t watchdog expired", $time);
		print_verdict();
	end
	// Main sequence
	initial begin
		t_reset();
		t_select();
		t_hs();
		t_tx();
		t_loop();
		t_echo();
		t_clk();
		t_rx();
		print_verdict();
	end
endmodule : test_uhp_uart
`default_nettype wire
